// File: bench/abr_store_model.sv
// Store and transducer listener facing the altitude beep reporter
`timescale 1ns/1ns
`default_nettype none
module abr_store_model
  import abr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Store port
  input wire logic nvm_rd_in,
  output logic nvm_rd_valid_out,
  output logic [16:0] nvm_rd_data_out,
  input wire logic nvm_wr_in,
  input wire logic [16:0] nvm_wr_data_in,
  output logic nvm_wr_done_out,
  // Transducer
  input wire logic tone_on_in,
  input wire logic tone_low_in
);
  // Held outside the reset, like a real non-volatile cell
  logic [16:0] mem_q = 17'h00400;
  logic [16:0] rd_data_q = 17'h00000;
  logic [1:0] prev_q = 2'h0;
  int wait_q = 0;
  int nreq_q = 0;
  int dur_q = 0;
  int seg_q[$];
  assign nvm_rd_data_out = rd_data_q;
  // --------------------------------------------------------------
  // Store: latency alternates between prompt and slow answers
  // --------------------------------------------------------------
  always @(posedge clk_in) begin
    nvm_rd_valid_out <= 1'b0;
    nvm_wr_done_out <= 1'b0;
    rd_data_q <= ~rd_data_q; // Released bus never keeps the last word
    if (rst_in) begin
      wait_q <= 0;
    end else if ((nvm_rd_in || nvm_wr_in) && !nvm_rd_valid_out && !nvm_wr_done_out) begin
      wait_q <= wait_q + 1;
      if (wait_q >= 1 + 5 * (nreq_q % 2)) begin
        wait_q <= 0;
        nreq_q <= nreq_q + 1;
        if (nvm_rd_in) begin
          nvm_rd_valid_out <= 1'b1;
          rd_data_q <= mem_q;
        end else begin
          nvm_wr_done_out <= 1'b1;
          mem_q <= nvm_wr_data_in; // Only a finished flight overwrites
        end
      end
    end
  end
  // --------------------------------------------------------------
  // Listener: logs each closed segment as kind plus cycle count
  // --------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      prev_q <= 2'h0;
      dur_q <= 0;
    end else if ({tone_low_in, tone_on_in} != prev_q) begin
      seg_q.push_back(prev_q[1] ? 20000 + dur_q : prev_q[0] ? 10000 + dur_q : dur_q);
      prev_q <= {tone_low_in, tone_on_in};
      dur_q <= 1;
    end else begin
      dur_q <= dur_q + 1;
    end
  end
endmodule : abr_store_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the altitude beep reporter
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import abr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic metric = 1'b0;
  logic flight_valid = 1'b0;
  logic ascent = 1'b0;
  logic [16:0] flight_alt = 17'h00000;
  logic rd, rd_valid, wr, wr_done, tick, tone_on, tone_low, idle;
  logic [16:0] rd_data, wr_data;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int wr_seen = 0;
  int exp_q[$];
  int unsigned seed = 88183;
  // Shortened durations in cycles, shared by the design and the expected report
  localparam logic [31:0] T_START = 32'h14;
  localparam logic [31:0] T_SHORT = 32'h4;
  localparam logic [31:0] T_LONG = 32'hC;
  localparam logic [31:0] T_BGAP = 32'h3;
  localparam logic [31:0] T_DPAUSE = 32'h8;
  localparam logic [31:0] T_GAP = 32'h1E;
  localparam logic [31:0] T_SAMPLE = 32'hA;
  // --------------------------------------------------------------
  // Design with short durations, and its far side
  // --------------------------------------------------------------
  abr_reporter #(.START_CYC(T_START), .SHORT_CYC(T_SHORT), .LONG_CYC(T_LONG), .BEEP_GAP_CYC(T_BGAP),
    .DIGIT_PAUSE_CYC(T_DPAUSE), .REPEAT_GAP_CYC(T_GAP), .SAMPLE_CYC(T_SAMPLE)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .metric_in(metric), .nvm_rd_out(rd), .nvm_rd_valid_in(rd_valid),
    .nvm_rd_data_in(rd_data), .nvm_wr_out(wr), .nvm_wr_data_out(wr_data), .nvm_wr_done_in(wr_done),
    .flight_valid_in(flight_valid), .flight_alt_in(flight_alt), .ascent_in(ascent),
    .sample_tick_out(tick), .tone_on_out(tone_on), .tone_low_out(tone_low), .idle_out(idle));
  abr_store_model PM (.clk_in(clk_in), .rst_in(rst_in), .nvm_rd_in(rd), .nvm_rd_valid_out(rd_valid),
    .nvm_rd_data_out(rd_data), .nvm_wr_in(wr), .nvm_wr_data_in(wr_data), .nvm_wr_done_out(wr_done),
    .tone_on_in(tone_on), .tone_low_in(tone_low));
  always #5 clk_in = ~clk_in;
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int clampv(input int v, input int m);
    return v > m ? m : v;
  endfunction : clampv
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] expv, input string what);
    samples_checked++;
    if (got !== expv) begin
      err_total++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, expv);
    end
  endtask : check
  // Expected segments: silence count, 10000 plus beep, 20000 plus start tone
  task automatic build(input int v, input int nrep);
    int d[$];
    int x;
    x = v;
    do begin
      d.push_front(x % 10);
      x = x / 10;
    end while (x > 0);
    for (int r = 0; r < nrep; r++) begin
      exp_q.push_back(r == 0 ? -1 : int'(T_GAP)); // Silence before the first start is not fixed
      exp_q.push_back(20000 + int'(T_START));
      foreach (d[i]) begin
        exp_q.push_back(int'(T_DPAUSE));
        if (d[i] == 0) exp_q.push_back(10000 + int'(T_LONG));
        else for (int k = 0; k < d[i]; k++) begin
          if (k > 0) exp_q.push_back(int'(T_BGAP));
          exp_q.push_back(10000 + int'(T_SHORT));
        end
      end
    end
  endtask : build
  task automatic listen(input string name);
    while (PM.seg_q.size() < exp_q.size()) @(negedge clk_in);
    while (exp_q.size() > 0) begin
      if (exp_q[0] != -1) check(PM.seg_q[0], exp_q[0], name);
      void'(PM.seg_q.pop_front());
      void'(exp_q.pop_front());
    end
    $display("test %s done", name);
  endtask : listen
  task automatic boot(input logic m);
    @(negedge clk_in);
    rst_in = 1'b1;
    metric = m;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    PM.seg_q.delete();
  endtask : boot
  task automatic fly(input int v);
    flight_alt = 17'(v);
    flight_valid = 1'b1;
    @(negedge clk_in);
    flight_valid = 1'b0;
  endtask : fly
  // Watchdog and store-request monitor
  always @(posedge clk_in) begin
    cycles++;
    if (wr === 1'b1) wr_seen++;
    if (cycles == 20000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    int v;
    int t0;
    boot(1'b0);
    build(1024, 2);
    repeat (100) @(negedge clk_in);
    fly(16); // Refused while reporting
    listen("boot");
    while (idle !== 1'b1) @(negedge clk_in);
    check(wr_seen, 0, "store untouched");
    check(PM.mem_q, 17'h00400, "stored value");
    check(tick, 1'b0, "tick before ascent");
    ascent = 1'b1;
    while (tick !== 1'b1) @(negedge clk_in);
    t0 = cycles;
    @(negedge clk_in);
    while (tick !== 1'b1) @(negedge clk_in);
    check(cycles - t0, int'(T_SAMPLE), "tick spacing");
    $display("test sampling done");
    ascent = 1'b0;
    v = xs() % 131072; // Over-range values get clamped
    fly(v);
    check(wr, 1'b1, "store request");
    check(wr_data, 17'(clampv(v, 99999)), "store data");
    check(tone_on, 1'b0, "silent while storing");
    while (wr !== 1'b0) @(negedge clk_in);
    check(PM.mem_q, 17'(clampv(v, 99999)), "stored flight");
    build(clampv(v, 99999), 3);
    listen("flight");
    check(idle, 1'b0, "no idle after flight");
    boot(1'b1);
    build(clampv(clampv(v, 99999), 9999), 2);
    listen("metric");
    check(PM.mem_q, 17'(clampv(v, 99999)), "kept over power cycle");
    while (idle !== 1'b1) @(negedge clk_in);
    fly(0);
    build(0, 2);
    listen("zero");
    stop_test();
  end
endmodule : testbench
`default_nettype wire

// File: src/abr_pkg.sv
// Package with timing, state and struct definitions of the altitude beep reporter
package abr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned ABR_CLK_PERIOD_NS = 10;
  localparam int unsigned ABR_CYC_PER_MS = 1000000 / ABR_CLK_PERIOD_NS;
  localparam int unsigned ABR_START_MS = 1000;      // Long low start tone
  localparam int unsigned ABR_SHORT_MS = 150;       // Short digit beep
  localparam int unsigned ABR_LONG_MS = 750;        // Long beep for a zero digit
  localparam int unsigned ABR_BEEP_GAP_MS = 150;    // Silence between beeps of a digit
  localparam int unsigned ABR_DIGIT_PAUSE_MS = 600; // Silence before each digit
  localparam int unsigned ABR_REPEAT_GAP_MS = 5000; // Silence before a repeat
  localparam int unsigned ABR_SAMPLE_MS = 100;      // Ten pressure samples a second
  localparam logic [31:0] ABR_START_CYC = 32'(ABR_START_MS * ABR_CYC_PER_MS);
  localparam logic [31:0] ABR_SHORT_CYC = 32'(ABR_SHORT_MS * ABR_CYC_PER_MS);
  localparam logic [31:0] ABR_LONG_CYC = 32'(ABR_LONG_MS * ABR_CYC_PER_MS);
  localparam logic [31:0] ABR_BEEP_GAP_CYC = 32'(ABR_BEEP_GAP_MS * ABR_CYC_PER_MS);
  localparam logic [31:0] ABR_DIGIT_PAUSE_CYC = 32'(ABR_DIGIT_PAUSE_MS * ABR_CYC_PER_MS);
  localparam logic [31:0] ABR_REPEAT_GAP_CYC = 32'(ABR_REPEAT_GAP_MS * ABR_CYC_PER_MS);
  localparam logic [31:0] ABR_SAMPLE_CYC = 32'(ABR_SAMPLE_MS * ABR_CYC_PER_MS);

  // ----------------------------------------------------------------
  // Altitude limits and report counts
  // ----------------------------------------------------------------
  localparam logic [16:0] ABR_MAX_IMPERIAL = 17'h1869F; // 99999, five digits
  localparam logic [16:0] ABR_MAX_METRIC = 17'h0270F;   // 9999, four digits
  localparam logic [2:0] ABR_TOP_DIGIT = 3'h4;
  localparam logic [1:0] ABR_BOOT_REPORTS = 2'h2;

  // ----------------------------------------------------------------
  // Sequencer states and state record
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ABR_S_LOAD = 9'h001,
    ABR_S_CONV = 9'h002,
    ABR_S_START = 9'h004,
    ABR_S_DPAUSE = 9'h008,
    ABR_S_BEEP = 9'h010,
    ABR_S_BGAP = 9'h020,
    ABR_S_GAP = 9'h040,
    ABR_S_IDLE = 9'h080,
    ABR_S_STORE = 9'h100
  } abr_state_e;

  typedef struct packed {
    abr_state_e state;
    logic [31:0] cnt;
    logic [31:0] scnt;
    logic [16:0] alt;
    logic [16:0] rem;
    logic [4:0][3:0] dig;
    logic [2:0] didx;
    logic [3:0] beeps;
    logic long_beep;
    logic [1:0] reps;
    logic rep_forever;
    logic metric;
    logic tone_on;
    logic tone_low;
    logic tick;
  } abr_regs_s;

endpackage : abr_pkg

// File: src/abr_reporter.sv
// Altitude beep reporter: decimal conversion, tone sequencing and store control
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Every report opens with long low tone
// - Digits sounded most significant first, five max
// - Metric build limits altitude to four digits
// - Short silent pause separates consecutive digits
// - Leading zeros skipped, inner zeros sounded
// - Zero is long beep, others N short
// - Five seconds silence, then whole report repeats
// - Power-up reads stored altitude, reports twice
// - Stored altitude changes only after new flight
// - Pressure sample tick ten times per second
// - After flight result, report repeats until powerdown
// - Store flight altitude before reporting it
module abr_reporter
  import abr_pkg::*;
#(
  parameter logic [31:0] START_CYC = ABR_START_CYC,
  parameter logic [31:0] SHORT_CYC = ABR_SHORT_CYC,
  parameter logic [31:0] LONG_CYC = ABR_LONG_CYC,
  parameter logic [31:0] BEEP_GAP_CYC = ABR_BEEP_GAP_CYC,
  parameter logic [31:0] DIGIT_PAUSE_CYC = ABR_DIGIT_PAUSE_CYC,
  parameter logic [31:0] REPEAT_GAP_CYC = ABR_REPEAT_GAP_CYC,
  parameter logic [31:0] SAMPLE_CYC = ABR_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Build strap
  input wire logic metric_in,
  // Non-volatile store
  output logic nvm_rd_out,
  input wire logic nvm_rd_valid_in,
  input wire logic [16:0] nvm_rd_data_in,
  output logic nvm_wr_out,
  output logic [16:0] nvm_wr_data_out,
  input wire logic nvm_wr_done_in,
  // Flight result and pressure sampling
  input wire logic flight_valid_in,
  input wire logic [16:0] flight_alt_in,
  input wire logic ascent_in,
  output logic sample_tick_out,
  // Transducer
  output logic tone_on_out,
  output logic tone_low_out,
  output logic idle_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] pow10(input logic [2:0] idx);
    unique case (idx)
      3'h0: pow10 = 17'h00001;
      3'h1: pow10 = 17'h0000A;
      3'h2: pow10 = 17'h00064;
      3'h3: pow10 = 17'h003E8;
      default: pow10 = 17'h02710;
    endcase
  endfunction : pow10

  function automatic logic [16:0] clamp(input logic [16:0] v, input logic met);
    logic [16:0] lim;
    lim = met ? ABR_MAX_METRIC : ABR_MAX_IMPERIAL;
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  abr_regs_s q;
  abr_regs_s d;
  logic cnt_end;
  logic [2:0] lead_c;
  logic [3:0] cur_dig;

  assign cnt_end = (q.cnt == 32'h00000001);
  assign cur_dig = q.dig[q.didx];

  // Highest nonzero digit; an all-zero value still sounds one zero
  always_comb begin
    lead_c = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (q.dig[i] != 4'h0) begin
        lead_c = 3'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt != 32'h00000000) begin
      d.cnt = q.cnt - 32'h00000001;
    end
    unique case (q.state)
      ABR_S_LOAD: begin
        d.metric = metric_in;
        if (nvm_rd_valid_in) begin
          d.alt = clamp(nvm_rd_data_in, metric_in);
          d.reps = ABR_BOOT_REPORTS;
          d.rep_forever = 1'b0;
          d.rem = clamp(nvm_rd_data_in, metric_in);
          d.dig = '0;
          d.didx = ABR_TOP_DIGIT;
          d.state = ABR_S_CONV;
        end
      end
      ABR_S_CONV: begin
        // Repeated subtraction per decade keeps the datapath to one comparator
        if (q.didx == 3'h0) begin
          d.dig[0] = q.rem[3:0];
          d.cnt = START_CYC;
          d.state = ABR_S_START;
        end else if (q.rem >= pow10(q.didx)) begin
          d.rem = q.rem - pow10(q.didx);
          d.dig[q.didx] = q.dig[q.didx] + 4'h1;
        end else begin
          d.didx = q.didx - 3'h1;
        end
      end
      ABR_S_START: begin
        if (cnt_end) begin
          d.didx = lead_c;
          d.cnt = DIGIT_PAUSE_CYC;
          d.state = ABR_S_DPAUSE;
        end
      end
      ABR_S_DPAUSE: begin
        if (cnt_end) begin
          d.long_beep = (cur_dig == 4'h0);
          d.beeps = (cur_dig == 4'h0) ? 4'h1 : cur_dig;
          d.cnt = (cur_dig == 4'h0) ? LONG_CYC : SHORT_CYC;
          d.state = ABR_S_BEEP;
        end
      end
      ABR_S_BEEP: begin
        if (cnt_end) begin
          d.beeps = q.beeps - 4'h1;
          if (q.beeps > 4'h1) begin
            d.cnt = BEEP_GAP_CYC;
            d.state = ABR_S_BGAP;
          end else if (q.didx == 3'h0) begin
            d.cnt = REPEAT_GAP_CYC;
            d.state = ABR_S_GAP;
          end else begin
            d.didx = q.didx - 3'h1;
            d.cnt = DIGIT_PAUSE_CYC;
            d.state = ABR_S_DPAUSE;
          end
        end
      end
      ABR_S_BGAP: begin
        if (cnt_end) begin
          d.cnt = SHORT_CYC;
          d.state = ABR_S_BEEP;
        end
      end
      ABR_S_GAP: begin
        if (cnt_end) begin
          if (q.rep_forever) begin
            d.cnt = START_CYC;
            d.state = ABR_S_START;
          end else if (q.reps > 2'h1) begin
            d.reps = q.reps - 2'h1;
            d.cnt = START_CYC;
            d.state = ABR_S_START;
          end else begin
            d.reps = 2'h0;
            d.state = ABR_S_IDLE;
          end
        end
      end
      ABR_S_IDLE: begin
        // Only a completed flight may replace the stored value
        if (flight_valid_in) begin
          d.alt = clamp(flight_alt_in, q.metric);
          d.state = ABR_S_STORE;
        end
      end
      ABR_S_STORE: begin
        if (nvm_wr_done_in) begin
          d.rep_forever = 1'b1;
          d.rem = q.alt;
          d.dig = '0;
          d.didx = ABR_TOP_DIGIT;
          d.state = ABR_S_CONV;
        end
      end
      default: begin
        d.state = ABR_S_LOAD;
      end
    endcase

    // Sample pacing runs only while waiting for the flight to finish
    if ((q.state == ABR_S_IDLE) && ascent_in) begin
      if (q.scnt <= 32'h00000001) begin
        d.scnt = SAMPLE_CYC;
        d.tick = 1'b1;
      end else begin
        d.scnt = q.scnt - 32'h00000001;
      end
    end else begin
      d.scnt = 32'h00000000;
    end

    // Registered tone drive follows the next state
    d.tone_on = (d.state == ABR_S_START) || (d.state == ABR_S_BEEP);
    d.tone_low = (d.state == ABR_S_START);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '{state: ABR_S_LOAD, default: '0};
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign nvm_rd_out = (q.state == ABR_S_LOAD);
  assign nvm_wr_out = (q.state == ABR_S_STORE);
  assign nvm_wr_data_out = q.alt;
  assign sample_tick_out = q.tick;
  assign tone_on_out = q.tone_on;
  assign tone_low_out = q.tone_low;
  assign idle_out = (q.state == ABR_S_IDLE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [16:0] recon_c;
  assign recon_c = 17'(q.dig[4] * 17'h02710) + 17'(q.dig[3] * 17'h003E8)
                 + 17'(q.dig[2] * 17'h00064) + 17'(q.dig[1] * 17'h0000A) + 17'(q.dig[0]);

  sequence seq_digit_done;
    (q.state == ABR_S_BEEP) && cnt_end && (q.beeps == 4'h1);
  endsequence

  sequence seq_report_end;
    seq_digit_done and (q.didx == 3'h0);
  endsequence

  a_start_tone_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.state == ABR_S_START) |-> (tone_on_out && tone_low_out))
    else $error("start tone not low");

  a_start_to_lead: assert property (@(posedge clk_in) disable iff (rst_in)
    ((q.state == ABR_S_START) && cnt_end) |=> ((q.state == ABR_S_DPAUSE) && (q.didx == $past(lead_c))))
    else $error("first digit is not the leading one");

  a_digit_order: assert property (@(posedge clk_in) disable iff (rst_in)
    (seq_digit_done and (q.didx != 3'h0)) |=> ((q.state == ABR_S_DPAUSE) && (q.didx == $past(q.didx) - 3'h1)))
    else $error("digit order broken");

  a_metric_limit: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.metric && (q.state == ABR_S_START)) |-> ((q.alt <= ABR_MAX_METRIC) && (q.dig[4] == 4'h0)))
    else $error("metric value exceeds four digits");

  a_digit_pause: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(q.state == ABR_S_DPAUSE) |-> ((q.cnt == DIGIT_PAUSE_CYC) && !tone_on_out))
    else $error("digit pause wrong");

  a_zero_long: assert property (@(posedge clk_in) disable iff (rst_in)
    ((q.state == ABR_S_DPAUSE) && cnt_end) |=>
      ((q.state == ABR_S_BEEP) && (q.beeps == (($past(cur_dig) == 4'h0) ? 4'h1 : $past(cur_dig)))
       && (q.cnt == (($past(cur_dig) == 4'h0) ? LONG_CYC : SHORT_CYC))))
    else $error("digit beep pattern wrong");

  a_repeat_gap: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_report_end |=> ((q.state == ABR_S_GAP) && (q.cnt == REPEAT_GAP_CYC) && !tone_on_out))
    else $error("repeat gap wrong");

  a_boot_twice: assert property (@(posedge clk_in) disable iff (rst_in)
    ((q.state == ABR_S_GAP) && cnt_end && !q.rep_forever && (q.reps == 2'h2)) |=>
      ((q.state == ABR_S_START) && (q.reps == 2'h1)))
    else $error("power-up report not repeated");

  a_write_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(nvm_wr_out) |-> ($past(flight_valid_in) && $past(q.state == ABR_S_IDLE)))
    else $error("store written without a flight");

  a_sample_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    sample_tick_out |-> ((q.scnt == SAMPLE_CYC) && $past(q.state == ABR_S_IDLE)))
    else $error("sample tick off pace");

  a_forever: assert property (@(posedge clk_in) disable iff (rst_in)
    ((q.state == ABR_S_GAP) && cnt_end && q.rep_forever) |=> (q.state == ABR_S_START))
    else $error("flight report did not repeat");

  a_store_first: assert property (@(posedge clk_in) disable iff (rst_in)
    (nvm_wr_out && !nvm_wr_done_in) |=> (nvm_wr_out && !tone_on_out))
    else $error("report began before store");

  a_conv_exact: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(q.state == ABR_S_START) && $past(q.state == ABR_S_CONV)) |-> (recon_c == q.alt))
    else $error("decimal conversion wrong");

endmodule : abr_reporter

`default_nettype wire
